//--- tfad_pkg.sv
package tfad_pkg;

  // ****************************************
  // Task file offsets (normalised, 0 to f)
  // ****************************************
  localparam logic [3:0] OFF_DATA = 4'h0;        // Sector data port
  localparam logic [3:0] OFF_ERR_FEAT = 4'h1;    // Error read, feature write
  localparam logic [3:0] OFF_COUNT = 4'h2;       // Transfer sector count
  localparam logic [3:0] OFF_SECTOR = 4'h3;      // Start sector number
  localparam logic [3:0] OFF_TRACK_LO = 4'h4;    // Track address low
  localparam logic [3:0] OFF_TRACK_HI = 4'h5;    // Track address high
  localparam logic [3:0] OFF_HEAD = 4'h6;        // Unit and head select
  localparam logic [3:0] OFF_STATE_CMD = 4'h7;   // State read, command write
  localparam logic [3:0] OFF_ALIAS_EVEN = 4'h8;  // Even data byte alias
  localparam logic [3:0] OFF_ALIAS_ODD = 4'h9;   // Odd data byte alias
  localparam logic [3:0] OFF_ALIAS_ERR = 4'hd;   // Error / feature alias
  localparam logic [3:0] OFF_SHADOW_CTRL = 4'he; // Shadow state, unit control
  localparam logic [3:0] OFF_UNIT_ADDR = 4'hf;   // Address readback, write slot unused

  // ****************************************
  // Mapping select values and I/O bases
  // ****************************************
  localparam logic [5:0] MAP_MEMORY = 6'h00;
  localparam logic [5:0] MAP_CONTIG = 6'h01;
  localparam logic [5:0] MAP_PRIMARY = 6'h02;
  localparam logic [5:0] MAP_SECONDARY = 6'h03;
  localparam logic [5:0] BASE_PRIMARY = 6'h1f;
  localparam logic [5:0] BASE_PRIMARY_ALT = 6'h3f;
  localparam logic [5:0] BASE_SECONDARY = 6'h17;
  localparam logic [5:0] BASE_SECONDARY_ALT = 6'h37;
  localparam logic [1:0] ALT_PAIR = 2'h3;        // A2..A1 of the upper two slots

  // ****************************************
  // Attribute copy-number register
  // ****************************************
  localparam logic [10:0] ATTR_COPY_ADDR = 11'h206;
  localparam int COPY_BIT = 4;                   // Copy number position
  localparam int UNIT_SELECT_BIT = 4;            // Unit select in head register

  // ****************************************
  // Error flag positions
  // ****************************************
  localparam int ERR_BAD_BLOCK = 7;
  localparam int ERR_ECC = 6;
  localparam int ERR_MISSING = 4;
  localparam int ERR_REJECTED = 2;
  localparam int ERR_GENERAL = 0;
  localparam logic [7:0] ERR_USED_MASK = 8'hd5;  // Bits 5, 3, 1 always zero

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h01;
  localparam logic [7:0] RST_COPY = 8'h00;

  // Decoding arrangement in force
  typedef enum logic [2:0] {
    TFAD_MAP_MEM,
    TFAD_MAP_CONTIG,
    TFAD_MAP_PRI,
    TFAD_MAP_SEC,
    TFAD_MAP_DISK,
    TFAD_MAP_NONE
  } tfad_map_t;

endpackage

//--- tfad_byte_reg.sv
// One host-written byte register with load enable
module tfad_byte_reg import tfad_pkg::*; #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] d,
  output logic [7:0] q
);

  // ****************************************
  // Storage
  // ****************************************
  // Load wins over hold, reset wins over both
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else if (load) begin
      q <= d;
    end
  end

endmodule

//--- tfad_decode.sv
// Address decode for the five task file arrangements
module tfad_decode import tfad_pkg::*; (
  input wire logic [5:0] mapping_select,
  input wire logic disk_mode,
  input wire logic [10:0] addr,
  input wire logic attr_select_n,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high_n,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  output logic hit,
  output logic [3:0] offset,
  output logic rd_req,
  output logic wr_req,
  output logic word_req,
  output logic high_lane_only,
  output logic attr_rd_req,
  output logic attr_wr_req
);

  // ****************************************
  // Cycle qualifiers
  // ****************************************
  tfad_map_t map;                    // Arrangement in force
  logic hit_c;                       // Raw hit
  logic [3:0] offset_c;              // Raw offset
  wire [5:0] base = addr[9:4];       // I/O window base
  wire alt_pair = addr[2:1] == ALT_PAIR;
  wire cs_any = !chip_select_low_n || !chip_select_high_n;
  wire mem_cyc = !mem_read_strobe_n || !mem_write_strobe_n;
  wire io_cyc = !io_read_strobe_n || !io_write_strobe_n;
  wire io_tf = !attr_select_n ? cs_any && io_cyc : 1'b0;
  wire attr_cyc = !disk_mode && !attr_select_n && !chip_select_low_n
    && addr == ATTR_COPY_ADDR;

  // Pick the arrangement; disk mode overrides mapping select
  // mapping select picks arrangement
  always_comb begin
    map = TFAD_MAP_NONE;
    if (disk_mode) begin
      map = TFAD_MAP_DISK;
    end else begin
      case (mapping_select)
        MAP_MEMORY: map = TFAD_MAP_MEM;
        MAP_CONTIG: map = TFAD_MAP_CONTIG;
        MAP_PRIMARY: map = TFAD_MAP_PRI;
        MAP_SECONDARY: map = TFAD_MAP_SEC;
        default: map = TFAD_MAP_NONE;
      endcase
    end
  end

  // ****************************************
  // Per-arrangement hit and offset
  // ****************************************
  always_comb begin
    hit_c = 1'b0;
    offset_c = OFF_DATA;
    case (map)
      TFAD_MAP_MEM: begin
        hit_c = attr_select_n && cs_any && mem_cyc;
        offset_c = addr[10] ? {3'b100, addr[0]} : addr[3:0];
      end
      TFAD_MAP_CONTIG: begin
        hit_c = io_tf;
        offset_c = addr[3:0];
      end
      // primary window and its alternate pair
      TFAD_MAP_PRI: begin
        hit_c = io_tf && (base == BASE_PRIMARY || (base == BASE_PRIMARY_ALT && alt_pair));
        offset_c = base == BASE_PRIMARY ? {1'b0, addr[2:0]} : {3'b111, addr[0]};
      end
      // secondary window and its alternate pair
      TFAD_MAP_SEC: begin
        hit_c = io_tf && (base == BASE_SECONDARY
          || (base == BASE_SECONDARY_ALT && alt_pair));
        offset_c = base == BASE_SECONDARY ? {1'b0, addr[2:0]} : {3'b111, addr[0]};
      end
      // low select command block, high select pair
      TFAD_MAP_DISK: begin
        hit_c = io_cyc && (chip_select_low_n != chip_select_high_n)
          && (!chip_select_low_n || alt_pair);
        offset_c = !chip_select_low_n ? {1'b0, addr[2:0]} : {3'b111, addr[0]};
      end
      default: begin
        hit_c = 1'b0;
        offset_c = OFF_DATA;
      end
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire mem_map = map == TFAD_MAP_MEM;
  wire disk_map = map == TFAD_MAP_DISK;
  assign hit = hit_c;
  assign offset = offset_c;
  assign rd_req = hit_c && (mem_map ? !mem_read_strobe_n : !io_read_strobe_n);
  assign wr_req = hit_c && (mem_map ? !mem_write_strobe_n : !io_write_strobe_n);
  // Disk mode: data port is always a word, the rest bytes on the low lane
  // word when both selects low
  assign word_req = disk_map ? offset_c == OFF_DATA : !chip_select_low_n && !chip_select_high_n;
  assign high_lane_only = !disk_map && chip_select_low_n && !chip_select_high_n;
  assign attr_rd_req = attr_cyc && !mem_read_strobe_n;
  assign attr_wr_req = attr_cyc && !mem_write_strobe_n;

endmodule

//--- tfad_top.sv
// What this block does
// - host stores copy number, card keeps it
// - mapping select chooses one of four arrangements
// - select 0: memory cycles, A10 byte window
// - select 1: I/O, A3-A0 offset only
// - select 2: primary base, alternate pair
// - select 3: secondary base, alternate pair
// - disk mode: chip selects pick block
// - offsets 0-7 read and write register sets
// - offsets 8, 9, d alias data and error
// - sixteen bit sector data port
// - data port takes words and bytes
// - word at data offset is data only, skips byte one
// - error register read only, writes hit feature
// - error flags at bits 7,6,4,2,0
// - abort and uncorrectable flags set by events
// - unit select compared with copy number
module tfad_top import tfad_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [10:0] addr,
  input wire logic attr_select_n,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high_n,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  input wire logic [5:0] mapping_select,
  input wire logic disk_mode,
  input wire logic [7:0] command_state_in,
  input wire logic bad_block_event,
  input wire logic ecc_failure_event,
  input wire logic sector_missing_event,
  input wire logic command_rejected_event,
  input wire logic general_error_event,
  input wire logic [15:0] sector_rd_data,
  output logic sector_pop,
  output logic sector_push,
  output logic [15:0] sector_wr_data,
  output logic cmd_strobe,
  output logic [7:0] command_code,
  output logic [7:0] feature_byte,
  output logic [7:0] transfer_sector_count,
  output logic [7:0] start_sector_number,
  output logic [7:0] track_address_low,
  output logic [7:0] track_address_high,
  output logic [7:0] unit_and_head_select,
  output logic [7:0] unit_control,
  output logic [7:0] card_copy_number,
  output logic card_selected
);

  // ****************************************
  // Address decode
  // ****************************************
  logic hit;                 // Task file hit
  logic [3:0] off;           // Normalised offset
  logic rd_req;              // Read strobe held on a hit
  logic wr_req;              // Write strobe held on a hit
  logic word_req;            // Sixteen bit access
  logic hi_only;             // Odd byte on upper lane only
  logic attr_rd_req;         // Copy register read
  logic attr_wr_req;         // Copy register write

  tfad_decode u_decode (
    .mapping_select(mapping_select),
    .disk_mode(disk_mode),
    .addr(addr),
    .attr_select_n(attr_select_n),
    .chip_select_low_n(chip_select_low_n),
    .chip_select_high_n(chip_select_high_n),
    .mem_read_strobe_n(mem_read_strobe_n),
    .mem_write_strobe_n(mem_write_strobe_n),
    .io_read_strobe_n(io_read_strobe_n),
    .io_write_strobe_n(io_write_strobe_n),
    .hit(hit),
    .offset(off),
    .rd_req(rd_req),
    .wr_req(wr_req),
    .word_req(word_req),
    .high_lane_only(hi_only),
    .attr_rd_req(attr_rd_req),
    .attr_wr_req(attr_wr_req)
  );

  // ****************************************
  // Strobe edge detection
  // ****************************************
  logic rd_req_q;            // Previous read level
  logic wr_req_q;            // Previous write level
  logic attr_rd_q;           // Previous attribute read level
  logic attr_wr_q;           // Previous attribute write level

  // Strobes are synchronous levels; each access acts once at its first cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_req_q <= 1'b0;
      wr_req_q <= 1'b0;
      attr_rd_q <= 1'b0;
      attr_wr_q <= 1'b0;
    end else begin
      rd_req_q <= rd_req;
      wr_req_q <= wr_req;
      attr_rd_q <= attr_rd_req;
      attr_wr_q <= attr_wr_req;
    end
  end

  wire rd_start = rd_req && !rd_req_q && card_selected;
  wire wr_start = wr_req && !wr_req_q;
  wire attr_rd_start = attr_rd_req && !attr_rd_q;
  wire attr_wr_start = attr_wr_req && !attr_wr_q;

  // ****************************************
  // Byte lanes and aliasing
  // ****************************************
  // Fold the duplicate error/feature slot onto offset 1
  function automatic logic [3:0] tfad_alias(input logic [3:0] o);
    return (o == OFF_ALIAS_ERR) ? OFF_ERR_FEAT : o;
  endfunction

  wire [7:0] lo_in = host_data_in[7:0];
  wire [7:0] hi_in = host_data_in[15:8];
  // A lone odd byte arrives on the upper lane
  wire [7:0] lo_val = (word_req || !hi_only) ? lo_in : hi_in;
  wire [3:0] lo_off = tfad_alias(word_req ? {off[3:1], 1'b0} : off);
  wire [3:0] hi_off = tfad_alias({off[3:1], 1'b1});
  // word at data offset is data only
  wire data_word = word_req && (off[3:1] == 3'b000 || off[3:1] == 3'b100);
  // 8 and 9 are data byte aliases
  wire data_even_b = !word_req && (off == OFF_DATA || off == OFF_ALIAS_EVEN);
  wire data_odd_b = !word_req && off == OFF_ALIAS_ODD;
  wire tf_access = !data_word && !data_even_b && !data_odd_b;

  // ****************************************
  // Byte register write enables
  // ****************************************
  logic [15:0] reg_we;       // Write enable per offset
  logic [7:0] reg_wv [16];   // Write value per offset

  for (genvar k = 0; k < 16; k++) begin : g_wr
    wire hi_match = word_req && hi_off == 4'(k);
    assign reg_we[k] = wr_start && tf_access && (lo_off == 4'(k) || hi_match);
    assign reg_wv[k] = hi_match ? hi_in : lo_val;
  end

  // offset 1 writes go to feature
  tfad_byte_reg #(.RESET_VALUE(RST_ZERO)) u_feature (
    .clk(clk), .rst(rst), .load(reg_we[OFF_ERR_FEAT]),
    .d(reg_wv[OFF_ERR_FEAT]), .q(feature_byte));
  tfad_byte_reg #(.RESET_VALUE(RST_COUNT)) u_count (
    .clk(clk), .rst(rst), .load(reg_we[OFF_COUNT]),
    .d(reg_wv[OFF_COUNT]), .q(transfer_sector_count));
  tfad_byte_reg #(.RESET_VALUE(RST_ZERO)) u_sector (
    .clk(clk), .rst(rst), .load(reg_we[OFF_SECTOR]),
    .d(reg_wv[OFF_SECTOR]), .q(start_sector_number));
  tfad_byte_reg #(.RESET_VALUE(RST_ZERO)) u_track_lo (
    .clk(clk), .rst(rst), .load(reg_we[OFF_TRACK_LO]),
    .d(reg_wv[OFF_TRACK_LO]), .q(track_address_low));
  tfad_byte_reg #(.RESET_VALUE(RST_ZERO)) u_track_hi (
    .clk(clk), .rst(rst), .load(reg_we[OFF_TRACK_HI]),
    .d(reg_wv[OFF_TRACK_HI]), .q(track_address_high));
  // Head register is loaded even when unselected, so selection can move
  tfad_byte_reg #(.RESET_VALUE(RST_ZERO)) u_head (
    .clk(clk), .rst(rst), .load(reg_we[OFF_HEAD]),
    .d(reg_wv[OFF_HEAD]), .q(unit_and_head_select));
  tfad_byte_reg #(.RESET_VALUE(RST_ZERO)) u_control (
    .clk(clk), .rst(rst), .load(reg_we[OFF_SHADOW_CTRL]),
    .d(reg_wv[OFF_SHADOW_CTRL]), .q(unit_control));
  // offset f write enable left unused

  // ****************************************
  // Copy number and unit selection
  // ****************************************
  // keep host copy number
  always_ff @(posedge clk) begin
    if (rst) begin
      card_copy_number <= RST_COPY;
    end else if (attr_wr_start) begin
      card_copy_number <= {3'b000, lo_in[COPY_BIT], 4'h0};
    end
  end

  // select compares unit bit with copy number
  always_ff @(posedge clk) begin
    if (rst) begin
      card_selected <= 1'b1;
    end else begin
      card_selected <= unit_and_head_select[UNIT_SELECT_BIT] == card_copy_number[COPY_BIT];
    end
  end

  // ****************************************
  // Command issue
  // ****************************************
  // Commands to the other unit on a shared bus are not ours
  wire cmd_accept = reg_we[OFF_STATE_CMD] && card_selected;

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_strobe <= 1'b0;
      command_code <= RST_ZERO;
    end else begin
      cmd_strobe <= cmd_accept;
      if (cmd_accept) begin
        command_code <= reg_wv[OFF_STATE_CMD];
      end
    end
  end

  // ****************************************
  // Error flags
  // ****************************************
  logic [7:0] error_flags;   // Sticky error register
  // core events set abort and others
  wire [7:0] err_events = {bad_block_event, ecc_failure_event, 1'b0, sector_missing_event,
    1'b0, command_rejected_event, 1'b0, general_error_event} & ERR_USED_MASK;
  // unused bit positions forced to zero
  wire [7:0] next_error = ((error_flags & ~{8{cmd_accept}}) | err_events) & ERR_USED_MASK;

  // New command clears; an event in the same cycle still sets
  always_ff @(posedge clk) begin
    if (rst) begin
      error_flags <= RST_ZERO;
    end else begin
      error_flags <= next_error;
    end
  end

  // ****************************************
  // Sector data port
  // ****************************************
  logic [7:0] even_hold;     // Even byte awaiting its odd partner
  wire push_word = wr_start && card_selected && data_word;
  wire push_odd = wr_start && card_selected && data_odd_b;

  // words and byte pairs to sector stream
  always_ff @(posedge clk) begin
    if (rst) begin
      even_hold <= RST_ZERO;
      sector_push <= 1'b0;
      sector_wr_data <= 16'h0000;
      sector_pop <= 1'b0;
    end else begin
      sector_push <= push_word || push_odd;
      sector_pop <= rd_start && (data_word || data_odd_b);
      if (wr_start && card_selected && data_even_b) begin
        even_hold <= lo_val;
      end
      if (push_word) begin
        sector_wr_data <= host_data_in;
      end else if (push_odd) begin
        sector_wr_data <= {lo_val, even_hold};
      end
    end
  end

  // ****************************************
  // Read selection
  // ****************************************
  logic [7:0] rd_tab [16];   // Read value per offset
  assign rd_tab[0] = sector_rd_data[7:0];
  assign rd_tab[1] = error_flags;
  assign rd_tab[2] = transfer_sector_count;
  assign rd_tab[3] = start_sector_number;
  assign rd_tab[4] = track_address_low;
  assign rd_tab[5] = track_address_high;
  assign rd_tab[6] = unit_and_head_select;
  assign rd_tab[7] = command_state_in;
  assign rd_tab[8] = sector_rd_data[7:0];
  assign rd_tab[9] = sector_rd_data[15:8];
  assign rd_tab[10] = RST_ZERO;
  assign rd_tab[11] = RST_ZERO;
  assign rd_tab[12] = RST_ZERO;
  assign rd_tab[13] = error_flags;
  assign rd_tab[14] = command_state_in;
  // Address readback: inverted head bits and one-hot unit select
  assign rd_tab[15] = {2'b00, ~unit_and_head_select[3:0],
    unit_and_head_select[UNIT_SELECT_BIT], ~unit_and_head_select[UNIT_SELECT_BIT]};

  wire [7:0] rd_byte = rd_tab[lo_off];
  wire [15:0] byte_placed = hi_only ? {rd_byte, 8'h00} : {8'h00, rd_byte};
  wire [15:0] next_read = data_word ? sector_rd_data
    : word_req ? {rd_tab[hi_off], rd_tab[lo_off]} : byte_placed;

  // Data captured at the first cycle and held for the whole strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      host_data_out <= 16'h0000;
      host_data_oe <= 1'b0;
    end else begin
      host_data_oe <= (rd_req && card_selected) || attr_rd_req;
      if (rd_start) begin
        host_data_out <= next_read;
      end else if (attr_rd_start) begin
        host_data_out <= {8'h00, card_copy_number};
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_read_open;
    rd_start ##1 rd_req;
  endsequence

  a_read_drives_bus: assert property (s_read_open |-> host_data_oe)
    else $error("read data not driven");
  a_word_read_pops: assert property (rd_start && data_word |=> sector_pop)
    else $error("word read did not pop");
  a_odd_byte_pairs: assert property (push_odd |=> sector_push
    && sector_wr_data[7:0] == $past(even_hold)) else $error("byte pair wrong");
  a_err_reserved_zero: assert property ((error_flags & ~ERR_USED_MASK) == 8'h00)
    else $error("reserved error bit set");
  a_err_set_wins: assert property (command_rejected_event |=> error_flags[ERR_REJECTED])
    else $error("abort flag lost");
  a_feature_not_error: assert property (reg_we[OFF_ERR_FEAT] && !cmd_accept
    && err_events == 8'h00 |=> $stable(error_flags)) else $error("error written");
  a_cmd_needs_select: assert property (cmd_strobe |-> $past(card_selected))
    else $error("command taken while unselected");
  a_copy_kept: assert property (attr_wr_start |=>
    card_copy_number[COPY_BIT] == $past(lo_in[COPY_BIT])) else $error("copy lost");
  a_slot_f_ignored: assert property (wr_start && !word_req && off == OFF_UNIT_ADDR
    |=> $stable(unit_control) && $stable(unit_and_head_select)) else $error("slot f wrote");
  a_alt_slot_offset: assert property (hit && disk_mode && chip_select_low_n
    |-> off[3:1] == 3'b111) else $error("alternate slot offset wrong");

endmodule

//--- tfad_core_model.sv
// Core side of the task file: read stream and pushed words
module tfad_core_model import tfad_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic sector_pop,
  input wire logic sector_push,
  input wire logic [15:0] sector_wr_data,
  output logic [15:0] sector_rd_data,
  output logic [7:0] command_state_in,
  output logic [15:0] last_push,
  output logic [7:0] pushes
);
  timeunit 1ns;
  timeprecision 1ps;
  assign command_state_in = 8'h50;
  // show-ahead word stream, steps on pop so a stuck pop shows
  always_ff @(posedge clk) begin
    if (rst) begin
      sector_rd_data <= 16'ha5c3;
      pushes <= 8'h00;
      last_push <= 16'h0000;
    end else begin
      if (sector_pop) sector_rd_data <= sector_rd_data + 16'h0101;
      if (sector_push) begin
        pushes <= pushes + 8'h01;
        last_push <= sector_wr_data;
      end
    end
  end
endmodule

//--- tb_top.sv
module tb_top import tfad_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, attr_n, cel_n, ceh_n, mrd_n, mwr_n, ird_n, iwr_n, dsk, mm, oe, pop, push, cs, sel;
  logic [10:0] addr;
  logic [15:0] din, dout, q, srd, lp, swr;
  logic [7:0] cst, cc, fb, cnt, sn, tl, th, hd, uc, cp, np;
  logic [5:0] map;
  logic [4:0] ev;
  logic [10:0] ba [5] = '{11'h002, 11'h7f2, 11'h1f2, 11'h172, 11'h002};
  logic [10:0] aa [5] = '{11'h00e, 11'h00e, 11'h3f6, 11'h376, 11'h006};
  int err_total = 0;
  int checked = 0;
  int ncmd = 0; // Command strobes seen by the host side
  tfad_top uut (.clk(clk), .rst(rst), .addr(addr), .attr_select_n(attr_n),
    .chip_select_low_n(cel_n), .chip_select_high_n(ceh_n), .mem_read_strobe_n(mrd_n),
    .mem_write_strobe_n(mwr_n), .io_read_strobe_n(ird_n), .io_write_strobe_n(iwr_n),
    .host_data_in(din), .host_data_out(dout), .host_data_oe(oe), .mapping_select(map),
    .disk_mode(dsk), .command_state_in(cst), .bad_block_event(ev[4]),
    .ecc_failure_event(ev[3]), .sector_missing_event(ev[2]), .command_rejected_event(ev[1]),
    .general_error_event(ev[0]), .sector_rd_data(srd), .sector_pop(pop), .sector_push(push),
    .sector_wr_data(swr), .cmd_strobe(cs), .command_code(cc), .feature_byte(fb),
    .transfer_sector_count(cnt), .start_sector_number(sn), .track_address_low(tl),
    .track_address_high(th), .unit_and_head_select(hd), .unit_control(uc),
    .card_copy_number(cp), .card_selected(sel));
  tfad_core_model core (.clk(clk), .rst(rst), .sector_pop(pop), .sector_push(push),
    .sector_wr_data(swr), .sector_rd_data(srd), .command_state_in(cst), .last_push(lp),
    .pushes(np));
  // Count accepted commands; reads the strobe as a flop would
  always @(posedge clk) begin
    if (cs === 1'b1) ncmd <= ncmd + 1;
  end
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One host cycle; strobe held three edges, released two edges before the next
  task acc(input logic wr, input logic [10:0] a, input logic [1:0] ce, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    {ceh_n, cel_n} <= ce;
    din <= d;
    {mrd_n, mwr_n, ird_n, iwr_n} <= ~{mm & ~wr, mm & wr, ~mm & ~wr, ~mm & wr};
    repeat (2) @(posedge clk);
    #1 q = dout;
    if (!wr) chk(16'(oe), 16'h0001);
    @(posedge clk);
    {mrd_n, mwr_n, ird_n, iwr_n, ceh_n, cel_n} <= 6'h3f;
    @(posedge clk);
  endtask
  task pulse(input logic [4:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 5'h00;
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog, over twenty-five times the expected run
  initial begin
    #20000;
    err_total = err_total + 1;
    give_verdict();
  end
  initial begin
    rst <= 1'b1;
    {mrd_n, mwr_n, ird_n, iwr_n, ceh_n, cel_n, attr_n} <= 7'h7f;
    {addr, din, map, dsk, ev, mm} <= '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(cnt, 8'h01);
    chk(cp, 8'h00);
    chk(sel, 1'b1);
    $display("test reset done");
    // every arrangement, count and alternate slot
    for (int i = 0; i < 5; i++) begin
      map <= (i == 4) ? 6'h00 : 6'(i);
      dsk <= (i == 4);
      attr_n <= (i == 0);
      mm = (i == 0);
      acc(1'b1, ba[i], 2'b10, 16'h0010 + 16'(i));
      acc(1'b0, ba[i], 2'b10, 16'h0000);
      chk(q[7:0], 8'h10 + 8'(i));
      chk(cnt, 8'h10 + 8'(i));
      acc(1'b1, aa[i], (i == 4) ? 2'b01 : 2'b10, 16'h0020 + 16'(i));
      chk(uc, 8'h20 + 8'(i));
    end
    dsk <= 1'b0;
    map <= 6'h03;
    acc(1'b1, 11'h1f2, 2'b10, 16'h00ff);
    chk(cnt, 8'h14);
    $display("test decode done");
    map <= 6'h01;
    acc(1'b1, 11'h001, 2'b10, 16'h003c);
    chk(fb, 8'h3c);
    acc(1'b0, 11'h001, 2'b10, 16'h0000);
    chk(q[7:0], 8'h00);
    pulse(5'h1f);
    // Host looks at busy before trusting the error byte
    acc(1'b0, 11'h007, 2'b10, 16'h0000);
    chk(q[7:0], 8'h50);
    acc(1'b0, 11'h001, 2'b10, 16'h0000);
    chk(q[7:0], 8'hd5);
    acc(1'b0, 11'h00d, 2'b10, 16'h0000);
    chk(q[7:0], 8'hd5);
    acc(1'b1, 11'h007, 2'b10, 16'h00ec);
    chk(cc, 8'hec);
    pulse(5'h0a);
    acc(1'b0, 11'h001, 2'b10, 16'h0000);
    chk(q[7:0], 8'h44);
    $display("test error done");
    acc(1'b1, 11'h000, 2'b00, 16'h1234);
    chk(lp, 16'h1234);
    acc(1'b1, 11'h008, 2'b10, 16'h0056);
    acc(1'b1, 11'h009, 2'b10, 16'h0078);
    chk(lp, 16'h7856);
    chk(np, 8'h02);
    acc(1'b0, 11'h000, 2'b00, 16'h0000);
    chk(q, 16'ha5c3);
    chk(srd, 16'ha6c4);
    acc(1'b1, 11'h002, 2'b00, 16'h3322);
    chk({sn, cnt}, 16'h3322);
    acc(1'b1, 11'h004, 2'b00, 16'hbbaa);
    acc(1'b0, 11'h004, 2'b00, 16'h0000);
    chk(q, 16'hbbaa);
    chk({th, tl}, 16'hbbaa);
    acc(1'b1, 11'h006, 2'b10, 16'h00e0);
    acc(1'b1, 11'h00f, 2'b10, 16'h00ff);
    chk(hd, 8'he0);
    $display("test data done");
    mm = 1'b1;
    acc(1'b1, 11'h206, 2'b10, 16'h0010);
    chk(cp, 8'h10);
    chk(sel, 1'b0);
    acc(1'b0, 11'h206, 2'b10, 16'h0000);
    chk(q, 16'h0010);
    mm = 1'b0;
    // Unselected card must drop a command
    acc(1'b1, 11'h007, 2'b10, 16'h0099);
    chk(cc, 8'hec);
    chk(16'(ncmd), 16'h0001);
    acc(1'b1, 11'h006, 2'b10, 16'h00f0);
    chk(sel, 1'b1);
    $display("test copy done");
    give_verdict();
  end
endmodule
